// [rlpm_far_model.sv]
// Far-side model: straps, interrupt sources, host strobes and pulls.
`default_nettype none
module rlpm_far_model
  import rlpm_pkg::*;
(
  input  wire logic [3:0]  irq_drv_n,            // Sources, flags 7..4.
  input  wire logic        clk,                  // Clock.
  input  wire logic [3:0]  strap,                // Strap levels.
  input  wire logic [3:0]  host_strobe,          // Host strobes D7..D4.
  input  wire logic [4:0]  sp1_drv,              // Serial pin drive.
  input  wire logic [7:0]  prog_flag_o,          // Design flags.
  input  wire logic [7:0]  prog_flag_oe_n,       // Design enables.
  input  wire logic [23:0] ext_data_bus_o,       // Design data.
  input  wire logic [23:0] ext_data_bus_oe_n,    // Design enables.
  input  wire logic [13:0] ext_address_bus_o,    // Design address.
  input  wire logic [13:0] ext_address_bus_oe_n, // Design enables.
  input  wire logic [4:0]  serial_port_one_o,    // Design serial.
  input  wire logic [4:0]  serial_port_one_oe_n, // Design enables.
  output logic [7:0]       prog_flag_i,          // Flag levels.
  output logic [23:0]      ext_data_bus_i,       // Data levels.
  output logic [13:0]      ext_address_bus_i,    // Address levels.
  output logic [4:0]       serial_port_one_i     // Serial levels.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        tog = 1'h0;
  logic [23:0] far_d;
  // Undriven address lines and data lines D23..8 and D2..0 flip each cycle so a stale value cannot pass as driven.
  always_ff @(posedge clk) tog <= !tog;
  assign far_d = {{16{tog}}, host_strobe, 1'h1, {3{tog}}};
  assign ext_data_bus_i = (~ext_data_bus_oe_n & ext_data_bus_o) |
                          (ext_data_bus_oe_n & far_d);
  assign ext_address_bus_i = (~ext_address_bus_oe_n & ext_address_bus_o) |
                             (ext_address_bus_oe_n & {14{tog}});
  assign prog_flag_i = (~prog_flag_oe_n & prog_flag_o) |
                       (prog_flag_oe_n & {irq_drv_n, strap});
  assign serial_port_one_i = (~serial_port_one_oe_n & serial_port_one_o) |
                             (serial_port_one_oe_n & sp1_drv);
endmodule : rlpm_far_model
`default_nettype wire

// [rlpm_irq_cond.sv]
// One interrupt conditioner: level or edge sensing of an active-low pin.
`default_nettype none
module rlpm_irq_cond #(
  parameter bit EDGE_OK  = 1'b1,
  parameter bit LEVEL_OK = 1'b1
) (
  input  wire logic clk,       // Processor clock.
  input  wire logic sys_rst,   // Synchronous reset, active high.
  input  wire logic pin_n,     // Combined pin level, active low.
  input  wire logic edge_sel,  // 1 selects edge sensing when both allowed.
  input  wire logic ack,       // Core acknowledge clears a latched edge.
  output logic      req        // Request to the core.
);
  logic prev_n;
  logic latched;
  wire  use_edge = EDGE_OK && (!LEVEL_OK || edge_sel);
  wire  fall     = prev_n && !pin_n;
  wire  next_req = use_edge ? (latched || fall) : !pin_n;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_n  <= 1'b1;
      latched <= 1'b0;
      req     <= 1'b0;
    end else begin
      prev_n  <= pin_n;
      // A new edge in the acknowledge cycle wins over the clear.
      latched <= use_edge && (fall || (latched && !ack));
      req     <= next_req && !(ack && !fall && use_edge);
    end
  end
endmodule : rlpm_irq_cond
`default_nettype wire

// [rlpm_pin_mux.sv]
// Reset-latched pin multiplexer: mode straps, shared buses, flags and IRQs.
//
// Behaviour
// - Bus pin function fixed only at reset
// - Serial port one pins reconfigurable anytime
// - Interrupt and flag work together concurrently
// - Mode pins sampled in reset, flags after; here caught at the first edge after reset releases
// - Mode C latched selects mode until reset
// - Mode C low: 14 address, 24 data
// - Upper eight data bits carry byte address
// - Mode C high: 16-bit host port, A0
// - Host ack open drain, mode D configured
// - Unmasked shared pin vectors, driven either way
// - Fixed sensitivity on flags 6..4; flag 7 and serial port one IRQs selectable
// - System control selects serial port one use
// - Byte DMA full mode, internal DMA host
`default_nettype none
module rlpm_pin_mux
  import rlpm_pkg::*;
#(
  parameter bit HAS_MODE_D = 1'b1
) (
  input  wire logic                   clk,           // Processor clock.
  input  wire logic                   sys_rst,       // Processor reset.
  // Core side.
  input  wire rlpm_pkg::rlpm_mem_req_t mem_req,      // External bus request.
  input  wire logic                   byte_mem_dma_req, // Byte DMA request.
  input  wire logic                   internal_port_dma_req, // INTERNAL_PORT_DMA request.
  input  wire logic [HOST_AD_W-1:0]   host_rdata,    // Data for host reads.
  input  wire logic                   host_rdata_oe, // Core returns host data.
  input  wire logic                   host_ack_core, // Core acknowledges host.
  input  wire logic [NUM_PF-1:0]      pf_out,        // Flag output values.
  input  wire logic [NUM_PF-1:0]      pf_dir_out,    // 1 makes flag an output.
  input  wire logic [NUM_OFLAG-1:0]   oflag_set,     // Dedicated flag values.
  input  wire logic                   sp1_is_flags,  // Serial port one as flags.
  input  wire logic                   sp1_flag_output, // Value for flag_output.
  input  wire logic [NUM_SP1-1:0]     sp1_core_out,  // Serial port outputs.
  input  wire logic [NUM_SP1-1:0]     sp1_core_oe,   // 1 drives serial pin.
  input  wire logic                   irq_edge_or_level_edge_sel, // Edge mode for irq_edge_or_level.
  input  wire logic [1:0]             sp1_irq_edge_sel, // Edge mode, sp1 IRQs.
  input  wire logic [5:0]             interrupt_mask, // 1 enables a source.
  input  wire logic [5:0]             irq_ack,       // Core acknowledge.
  output logic                        op_mode,       // Latched mode, 1 = host.
  output logic [NUM_MODE-1:0]         mode_held,     // Latched mode pins.
  output logic                        host_ack_cfg,  // Latched mode D.
  output rlpm_pkg::rlpm_irq_t         irq_pending,   // Unmasked requests.
  output logic                        irq_vector,    // Any unmasked request vectors.
  output logic [NUM_PF-1:0]           pf_in,         // Flag pin levels.
  output logic                        flag_input,    // Serial flag input.
  output logic [NUM_SP1-1:0]          sp1_core_in,   // Serial port inputs.
  output rlpm_pkg::rlpm_host_ctl_t    host_ctl,      // Host port strobes.
  output logic [HOST_AD_W-1:0]        host_ad_in,    // Host addr/data in.
  output logic [DATA_W-1:0]           ext_data_in,   // External data in.
  output logic                        dma_grant_byte_mem_dma, // Byte DMA allowed.
  output logic                        dma_grant_internal_port_dma, // Internal DMA allowed.
  // Pins; each output enable is low while the pin is driven.
  input  wire logic [ADDR_W-1:0]      ext_address_bus_i, // Address pins in.
  output logic [ADDR_W-1:0]           ext_address_bus_o, // Address pins out.
  output logic [ADDR_W-1:0]           ext_address_bus_oe_n, // Address enable.
  input  wire logic [DATA_W-1:0]      ext_data_bus_i, // Data pins in.
  output logic [DATA_W-1:0]           ext_data_bus_o, // Data pins out.
  output logic [DATA_W-1:0]           ext_data_bus_oe_n, // Data enable.
  input  wire logic [NUM_PF-1:0]      prog_flag_i,   // Flag pins in.
  output logic [NUM_PF-1:0]           prog_flag_o,   // Flag pins out.
  output logic [NUM_PF-1:0]           prog_flag_oe_n, // Flag enable.
  input  wire logic [NUM_SP1-1:0]     serial_port_one_i, // Serial pins in.
  output logic [NUM_SP1-1:0]          serial_port_one_o, // Serial pins out.
  output logic [NUM_SP1-1:0]          serial_port_one_oe_n, // Serial enable.
  output logic [NUM_OFLAG-1:0]        dedicated_output_flags // Flag outputs.
);
  ////////////////////////////////////////////////////////////////////////////
  // Mode straps.
  logic rst_d;
  wire  rst_release = rst_d && !sys_rst;
  wire  host_mode   = (op_mode == RLPM_HOST);

  // bus function frozen
  // The straps are caught at the first clocked edge after reset releases,
  // so the asynchronous pin level never reaches a reset value.
  always_ff @(posedge clk) begin
    rst_d <= sys_rst;
    if (rst_release) begin
      mode_held    <= prog_flag_i[NUM_MODE-1:0];
      op_mode      <= prog_flag_i[MODE_C_BIT];
      host_ack_cfg <= HAS_MODE_D && prog_flag_i[MODE_D_BIT];
    end else if (sys_rst) begin
      mode_held    <= MODE_RST;
      op_mode      <= RLPM_FULL_MEM;
      host_ack_cfg <= 1'b0;
    end
  end

  // Pins stay released until the straps are held, so mode pins float freely.
  logic run;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run <= 1'b0;
    end else begin
      run <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared address and data pins.
  // full memory bus
  wire [ADDR_W-1:0] full_addr_oe_n = run ? '0 : '1;
  wire [DATA_W-1:0] full_wdata = mem_req.byte_access ?
    {mem_req.byte_addr, mem_req.wdata[DATA_W-BYTE_ADR_W-1:0]} : mem_req.wdata;
  wire [DATA_W-1:0] full_data_oe_n =
    mem_req.byte_access ? {{BYTE_ADR_W{~run}},
                           {(DATA_W-BYTE_ADR_W){~(run && mem_req.drive_data)}}}
                        : {DATA_W{~(run && mem_req.drive_data)}};

  // host port layout
  // Host mode: A0 is a plain address pin; A13..1 carry host data bits
  // 12..0 and the lower data pins carry bits 15..13 and the strobes.
  localparam int HL = ADDR_W - 1;
  wire host_drv = run && host_rdata_oe;
  wire ack_low  = run && (host_ack_cfg ? !host_ack_core : host_ack_core);
  wire [ADDR_W-1:0] host_addr_o   = {host_rdata[HL-1:0], mem_req.addr[0]};
  wire [ADDR_W-1:0] host_addr_oe_n = {{HL{~host_drv}}, ~run};
  wire [7:0] host_low_o =
    {4'h0, 1'b0, host_rdata[HOST_AD_W-1:HL]};
  wire [7:0] host_low_oe_n =
    {4'hf, ~ack_low, {3{~host_drv}}};
  wire [DATA_W-1:0] host_data_o =
    {mem_req.wdata[DATA_W-1:BYTE_ADR_W], host_low_o};
  wire [DATA_W-1:0] host_data_oe_n =
    {{(DATA_W-BYTE_ADR_W){~(run && mem_req.drive_data)}}, host_low_oe_n};

  wire [ADDR_W-1:0] next_a_o    = host_mode ? host_addr_o : mem_req.addr;
  wire [ADDR_W-1:0] next_a_oe_n = host_mode ? host_addr_oe_n : full_addr_oe_n;
  wire [DATA_W-1:0] next_d_o    = host_mode ? host_data_o : full_wdata;
  wire [DATA_W-1:0] next_d_oe_n = host_mode ? host_data_oe_n : full_data_oe_n;

  wire [7:0] dl = ext_data_bus_i[7:0];
  wire rlpm_host_ctl_t next_host_ctl = host_mode ?
    rlpm_host_ctl_t'{write_en_n: dl[7], read_en_n: dl[6],
                     addr_latch: dl[5], select_n: dl[4]} :
    rlpm_host_ctl_t'{write_en_n: 1'b1, read_en_n: 1'b1,
                     addr_latch: 1'b0, select_n: 1'b1};
  wire [HOST_AD_W-1:0] next_host_ad =
    {dl[2:0], ext_address_bus_i[ADDR_W-1:1]};

  wire next_byte_mem_dma = run && !host_mode && byte_mem_dma_req;
  wire next_internal_port_dma = run && host_mode && internal_port_dma_req;

  // external decode
  // In host mode A0 keeps driving the core address bit so external logic
  // can decode peripherals from it with the memory select strobes.
  always_ff @(posedge clk) begin
    ext_address_bus_o    <= next_a_o;
    ext_address_bus_oe_n <= sys_rst ? '1 : next_a_oe_n;
    ext_data_bus_o       <= next_d_o;
    ext_data_bus_oe_n    <= sys_rst ? '1 : next_d_oe_n;
    host_ctl             <= next_host_ctl;
    host_ad_in           <= host_mode ? next_host_ad : '0;
    ext_data_in          <= ext_data_bus_i;
    dma_grant_byte_mem_dma       <= !sys_rst && next_byte_mem_dma;
    dma_grant_internal_port_dma       <= !sys_rst && next_internal_port_dma;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programmable flags and dedicated flags.
  // output-only flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dedicated_output_flags <= '0;
    end else begin
      dedicated_output_flags <= oflag_set;
    end
  end

  // flag and irq share
  // A flag programmed as output still feeds its interrupt from the driven
  // value, so software can raise the interrupt itself.
  wire [NUM_PF-1:0] pf_level =
    (pf_dir_out & pf_out) | (~pf_dir_out & prog_flag_i);
  always_ff @(posedge clk) begin
    prog_flag_o    <= pf_out;
    prog_flag_oe_n <= (sys_rst || !run) ? '1 : ~pf_dir_out;
    pf_in          <= pf_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port one, reconfigurable at run time.
  // run time select
  wire [NUM_SP1-1:0] sp_flag_oe_n = ~(NUM_SP1'(1) << SP1_FO);
  wire [NUM_SP1-1:0] sp_flag_o    = NUM_SP1'(sp1_flag_output) << SP1_FO;
  always_ff @(posedge clk) begin
    serial_port_one_o    <= sp1_is_flags ? sp_flag_o : sp1_core_out;
    serial_port_one_oe_n <= (sys_rst || !run) ? '1 :
                            (sp1_is_flags ? sp_flag_oe_n : ~sp1_core_oe);
    sp1_core_in          <= sp1_is_flags ? '1 : serial_port_one_i;
    flag_input           <= sp1_is_flags && serial_port_one_i[SP1_FI];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt conditioning.
  // fixed or selectable sensitivity
  wire [5:0] pin_n = {pf_level[PF_IRQ_EDGE_OR_LEVEL], pf_level[PF_IRQ_LEVEL_ONE],
                      pf_level[PF_IRQ_LEVEL_ZERO], pf_level[PF_IRQ_EDGE_ONLY],
                      !sp1_is_flags || serial_port_one_i[SP1_IRQ1],
                      !sp1_is_flags || serial_port_one_i[SP1_IRQ0]};
  wire [5:0] edge_sel = {irq_edge_or_level_edge_sel, 1'b0, 1'b0, 1'b1, sp1_irq_edge_sel};
  localparam bit [5:0] EDGE_OK  = 6'b100111;
  localparam bit [5:0] LEVEL_OK = 6'b111011;
  wire [5:0] raw_req;

  for (genvar i = 0; i < 6; i++) begin : g_irq
    rlpm_irq_cond #(
      .EDGE_OK  (EDGE_OK[i]),
      .LEVEL_OK (LEVEL_OK[i])
    ) u_cond (
      .clk      (clk),
      .sys_rst  (sys_rst || !run),
      .pin_n    (pin_n[i]),
      .edge_sel (edge_sel[i]),
      .ack      (irq_ack[i]),
      .req      (raw_req[i])
    );
  end

  wire [5:0] masked = raw_req & interrupt_mask;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_pending <= '0;
      irq_vector  <= 1'b0;
    end else begin
      irq_pending <= rlpm_irq_t'(masked);
      irq_vector  <= |masked;
    end
  end
endmodule : rlpm_pin_mux
`default_nettype wire

// [rlpm_pin_mux_monitor.sv]
// Checker for the pin multiplexer, bound to its top module.
`default_nettype none
module rlpm_pin_mux_monitor
  import rlpm_pkg::*;
(
  input wire logic                  clk,                    // Clock.
  input wire logic                  sys_rst,                // Reset.
  input wire logic [NUM_PF-1:0]     prog_flag_i,            // Flag pins.
  input wire logic [NUM_MODE-1:0]   mode_held,              // Held straps.
  input wire logic                  op_mode,                // Mode.
  input wire logic [NUM_OFLAG-1:0]  oflag_set,              // Flag values.
  input wire logic [NUM_OFLAG-1:0]  dedicated_output_flags, // Flags.
  input wire logic                  sp1_is_flags,           // Port use.
  input wire logic [NUM_SP1-1:0]    serial_port_one_oe_n,   // Enables.
  input wire logic                  dma_grant_byte_mem_dma,         // Grant.
  input wire logic                  dma_grant_internal_port_dma,         // Grant.
  input wire logic [ADDR_W-1:0]     ext_address_bus_oe_n,   // Enables.
  input wire logic [DATA_W-1:0]     ext_data_bus_oe_n,      // Enables.
  input wire logic [5:0]            interrupt_mask,         // Mask.
  input wire rlpm_pkg::rlpm_irq_t   irq_pending             // Requests.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] run_cnt;
  // Pins only settle two edges after release, so pin checks wait for three.
  always_ff @(posedge clk) begin
    if (sys_rst) run_cnt <= 2'h0;
    else if (run_cnt != 2'h3) run_cnt <= run_cnt + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence release_s;
    !sys_rst && $past(sys_rst);
  endsequence
  sequence running_s;
    run_cnt == 2'h3;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  capture_mode_a: assert property (release_s |=>
    mode_held == $past(prog_flag_i[NUM_MODE-1:0]))
    else $error("mode pins not captured at release");
  mode_stable_a: assert property (run_cnt >= 2'h2 |->
    $stable(mode_held)) else $error("held mode changed after reset");
  op_mode_a: assert property (run_cnt != 2'h0 |->
    op_mode == mode_held[MODE_C_BIT]) else $error("mode not from pin C");
  full_addr_a: assert property (running_s ##0 !op_mode |->
    ext_address_bus_oe_n == '0) else $error("address pins not driven");
  host_pins_a: assert property (running_s ##0 op_mode |->
    !ext_address_bus_oe_n[0] && &ext_data_bus_oe_n[7:4])
    else $error("host mode pin enables wrong");
  dma_mode_a: assert property (!(dma_grant_byte_mem_dma && op_mode) &&
    !(dma_grant_internal_port_dma && !op_mode)) else $error("grant in wrong mode");
  oflag_a: assert property (running_s |->
    dedicated_output_flags == $past(oflag_set)) else $error("flag out");
  sp1_flag_a: assert property (running_s ##0 $past(sp1_is_flags) |->
    serial_port_one_oe_n == 5'h17) else $error("serial flag enables");
  irq_mask_a: assert property (
    (6'(irq_pending) & ~$past(interrupt_mask)) == 6'h0)
    else $error("masked request pending");
endmodule : rlpm_pin_mux_monitor
bind rlpm_pin_mux rlpm_pin_mux_monitor u_mon (.*);
`default_nettype wire

// [rlpm_pin_mux_tb.sv]
// Self-checking bench for the reset-latched pin multiplexer.
`default_nettype none
module rlpm_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rlpm_pkg::*;
  logic clk = 1'h0;
  logic sys_rst, byte_mem_dma_req, internal_port_dma_req, host_rdata_oe;
  logic host_ack_core, sp1_is_flags, sp1_flag_output, irq_edge_or_level_edge_sel;
  logic op_mode, host_ack_cfg, irq_vector, flag_input;
  logic dma_grant_byte_mem_dma, dma_grant_internal_port_dma;
  rlpm_mem_req_t  mem_req;
  rlpm_irq_t      irq_pending;
  rlpm_host_ctl_t host_ctl;
  logic [1:0]  sp1_irq_edge_sel;
  logic [2:0]  oflag_set, dedicated_output_flags;
  logic [3:0]  mode_held, strap, irq_drv_n, host_strobe;
  logic [4:0]  sp1_core_out, sp1_core_oe, sp1_core_in, sp1_drv;
  logic [4:0]  serial_port_one_i, serial_port_one_o, serial_port_one_oe_n;
  logic [5:0]  interrupt_mask, irq_ack;
  logic [7:0]  pf_out, pf_dir_out, pf_in;
  logic [7:0]  prog_flag_i, prog_flag_o, prog_flag_oe_n;
  logic [13:0] ext_address_bus_i, ext_address_bus_o, ext_address_bus_oe_n;
  logic [15:0] host_rdata, host_ad_in;
  logic [23:0] ext_data_in, ext_data_bus_i, ext_data_bus_o, ext_data_bus_oe_n;
  int          err_count = 0;
  int          n_checks = 0;
  rlpm_pin_mux #(.HAS_MODE_D(1'h1)) uut (.*);
  rlpm_far_model far (.*);
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [23:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic results();
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // Edge requests take two flops, so a bounded wait beats a fixed delay.
  task automatic wirq(input int b, input logic v);
    int i;
    for (i = 0; i < 20 && irq_pending[b] !== v; i++) cyc(1);
    chk("irq_pending", 24'(v), 24'(irq_pending[b]));
    if (i == 20) results();
  endtask : wirq
  task automatic boot(input logic [3:0] s);
    strap = s;
    sys_rst = 1'h1;
    cyc(16);
    sys_rst = 1'h0;
    cyc(3);
  endtask : boot
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {byte_mem_dma_req, internal_port_dma_req, host_rdata, host_rdata_oe,
     host_ack_core, pf_out, pf_dir_out, oflag_set, sp1_is_flags, irq_ack,
     sp1_flag_output, sp1_core_out, sp1_core_oe, irq_edge_or_level_edge_sel, mem_req,
     sp1_irq_edge_sel, interrupt_mask} = '0;
    {sys_rst, irq_drv_n, host_strobe, sp1_drv} = '1;
    boot(4'h0);
    chk("mode_held", 4'h0, {op_mode, mode_held});
    strap = 4'h4;
    mem_req.addr = 14'h2a5c;
    mem_req.wdata = 24'h123456;
    mem_req.drive_data = 1'h1;
    oflag_set = 3'h5;
    {byte_mem_dma_req, internal_port_dma_req} = 2'h3;
    cyc(4);
    chk("mode_held", 4'h0, mode_held);
    chk("addr", 14'h2a5c, ext_address_bus_o);
    chk("enables", 24'h0, ext_data_bus_oe_n | ext_address_bus_oe_n);
    chk("data", 24'h123456, ext_data_bus_o);
    chk("data_in", 24'h123456, ext_data_in);
    chk("oflags", 3'h5, dedicated_output_flags);
    chk("grants", 2'h2, {dma_grant_byte_mem_dma, dma_grant_internal_port_dma});
    mem_req.byte_access = 1'h1;
    mem_req.byte_addr = 8'h9c;
    pf_dir_out = 8'h80;
    interrupt_mask = 6'h20;
    cyc(2);
    chk("byte_data", 24'h9c3456, ext_data_bus_o);
    chk("pf_in", 8'h74, pf_in);
    chk("pf_oe_n", 8'h7f, prog_flag_oe_n);
    wirq(5, 1'h1);
    chk("irq_vector", 1'h1, irq_vector);
    pf_out = 8'h80;
    wirq(5, 1'h0);
    interrupt_mask = 6'h04;
    irq_drv_n = 4'he;
    wirq(2, 1'h1);
    irq_drv_n = 4'hf;
    cyc(4);
    chk("edge_held", 1'h1, irq_pending.edge_only);
    irq_ack = 6'h04;
    cyc(1);
    irq_ack = 6'h0;
    wirq(2, 1'h0);
    interrupt_mask = 6'h08;
    irq_drv_n = 4'hd;
    wirq(3, 1'h1);
    irq_drv_n = 4'hf;
    wirq(3, 1'h0);
    interrupt_mask = 6'h0;
    irq_drv_n = 4'hb;
    cyc(4);
    chk("masked", 6'h0, irq_pending);
    chk("irq_vector", 1'h0, irq_vector);
    // A one-cycle low on flag 7 must be held once edge sensing is chosen.
    irq_edge_or_level_edge_sel = 1'h1;
    interrupt_mask = 6'h20;
    pf_out = 8'h00;
    cyc(1);
    pf_out = 8'h80;
    wirq(5, 1'h1);
    cyc(4);
    chk("irq_edge_or_level_edge", 1'h1, irq_pending.edge_or_level);
    irq_ack = 6'h20;
    cyc(1);
    irq_ack = 6'h0;
    wirq(5, 1'h0);
    {irq_drv_n, sp1_is_flags, sp1_flag_output} = 6'h3f;
    sp1_drv = 5'h1a;
    interrupt_mask = 6'h01;
    cyc(2);
    chk("sp1", 7'h5e, {serial_port_one_oe_n, serial_port_one_o[3],
        flag_input});
    chk("sp1_core_in", 5'h1f, sp1_core_in);
    wirq(0, 1'h1);
    sp1_irq_edge_sel = 2'h2;
    interrupt_mask = 6'h02;
    sp1_drv = 5'h18;
    cyc(1);
    sp1_drv = 5'h1a;
    wirq(1, 1'h1);
    irq_ack = 6'h02;
    cyc(1);
    irq_ack = 6'h0;
    wirq(1, 1'h0);
    sp1_is_flags = 1'h0;
    sp1_core_oe = 5'h1f;
    sp1_core_out = 5'h0a;
    cyc(2);
    chk("sp1_out", 10'h00a, {serial_port_one_oe_n, serial_port_one_o});
    chk("sp1_core_in", 5'h0a, sp1_core_in);
    host_strobe = 4'h5;
    mem_req.addr = 14'h1;
    boot(4'hc);
    chk("mode", 2'h3, {op_mode, host_ack_cfg});
    chk("host_ctl", 4'h5, host_ctl);
    chk("a0", 2'h1, {ext_address_bus_oe_n[0], ext_address_bus_o[0]});
    chk("a_oe_n", 13'h1fff, ext_address_bus_oe_n[13:1]);
    chk("d_hi", 16'h1234, ext_data_bus_o[23:8]);
    chk("grants", 2'h1, {dma_grant_byte_mem_dma, dma_grant_internal_port_dma});
    chk("ack_pin", 1'h0, ext_data_bus_i[3]);
    host_ack_core = 1'h1;
    cyc(2);
    chk("ack_pin", 2'h3, {ext_data_bus_oe_n[3], ext_data_bus_i[3]});
    // Host read data goes out on A13..1 and D2..0 and loops back in.
    host_rdata = 16'hb6d5;
    host_rdata_oe = 1'h1;
    cyc(2);
    chk("host_a", 14'h2dab, ext_address_bus_o);
    chk("a_oe_n", 13'h0, ext_address_bus_oe_n[13:1]);
    chk("host_d_lo", 3'h5, ext_data_bus_o[2:0]);
    chk("host_ad_in", 16'hb6d5, host_ad_in);
    results();
  end
endmodule : rlpm_pin_mux_tb
`default_nettype wire

// [rlpm_pkg.sv]
// Package for the reset-latched pin multiplexer: modes, widths and carriers.
`default_nettype none
package rlpm_pkg;
  localparam int ADDR_W      = 14;
  localparam int DATA_W      = 24;
  localparam int HOST_AD_W   = 16;
  localparam int BYTE_ADR_W  = 8;
  localparam int NUM_MODE    = 4;
  localparam int NUM_PF      = 8;
  localparam int NUM_OFLAG   = 3;
  localparam int NUM_SP1     = 5;
  localparam int MODE_C_BIT  = 2;
  localparam int MODE_D_BIT  = 3;
  localparam int PF_IRQ_EDGE_ONLY     = 4;
  localparam int PF_IRQ_LEVEL_ZERO    = 5;
  localparam int PF_IRQ_LEVEL_ONE    = 6;
  localparam int PF_IRQ_EDGE_OR_LEVEL     = 7;
  localparam int SP1_IRQ0    = 0;
  localparam int SP1_IRQ1    = 1;
  localparam int SP1_FI      = 2;
  localparam int SP1_FO      = 3;
  localparam logic [NUM_MODE-1:0] MODE_RST = 4'h0;

  typedef enum logic [0:0] {
    RLPM_FULL_MEM = 1'b0,
    RLPM_HOST     = 1'b1
  } rlpm_mode_t;

  // Core-side memory request: address, write data and strobes.
  typedef struct packed {
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [BYTE_ADR_W-1:0] byte_addr;
    logic                  drive_data;
    logic                  byte_access;
  } rlpm_mem_req_t;

  // Host-port control inputs as seen on the shared data pins.
  typedef struct packed {
    logic write_en_n;
    logic read_en_n;
    logic addr_latch;
    logic select_n;
  } rlpm_host_ctl_t;

  // Interrupt requests presented to the core, one per source.
  typedef struct packed {
    logic edge_or_level;
    logic level_one;
    logic level_zero;
    logic edge_only;
    logic sp1_irq1;
    logic sp1_irq0;
  } rlpm_irq_t;
endpackage : rlpm_pkg
`default_nettype wire
